// ---- tb/ledseq_panel.sv ----
`timescale 1ns/1ps
`default_nettype none
module ledseq_panel
(
  // dial set by the bench
  input wire logic [7:0] dial_i,
  // switch contacts
  output logic [7:0] sw_o
);
  // contacts are plain levels, moved only while reset is held
  assign sw_o = dial_i;
endmodule
`default_nettype wire

// ---- tb/ledseq_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module ledseq_top_monitor
  import ledseq_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // inputs
  input wire logic [7:0] field_network_node_i,
  input wire logic device_failed_i,
  input wire logic configured_i,
  // indicators
  input wire logic dev_power_led_o,
  input wire logic dev_fault_led_o,
  input wire logic [7:0] chan_red_led_o,
  input wire logic [7:0] chan_amber_led_o,
  input wire logic powerup_done_o
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);
  a_green_on: assert property ($past(arst_n_i) |-> dev_power_led_o)
    else $error("green lamp dark");
  a_fault_early: assert property ($past(arst_n_i) && !powerup_done_o |-> dev_fault_led_o)
    else $error("fault lamp dark in power-up");
  // each walk step moves the lit pattern up by one channel
  a_red_walk: assert property (!powerup_done_o && $changed(chan_red_led_o) && $past(chan_amber_led_o) == 8'h00
    |-> chan_red_led_o[7:1] == $past(chan_red_led_o[6:0]))
    else $error("red walk out of order");
  a_amber_walk: assert property (!powerup_done_o && $changed(chan_amber_led_o)
    |-> chan_amber_led_o[7:1] == $past(chan_amber_led_o[6:0]))
    else $error("amber walk out of order");
  // bench runs with a step of four cycles
  a_step_gap: assert property (!powerup_done_o && $changed({chan_red_led_o, chan_amber_led_o})
    |=> $stable({chan_red_led_o, chan_amber_led_o})[*3])
    else $error("walk step too short");
  a_addr_show: assert property ($fell(chan_amber_led_o[7]) && !powerup_done_o
    |-> (chan_red_led_o == field_network_node_i && dev_fault_led_o)[*8]
    ##[10:16] (powerup_done_o && !dev_fault_led_o))
    else $error("address display wrong");
  a_fault_run: assert property (powerup_done_o && $past(powerup_done_o)
    |-> dev_fault_led_o == $past(device_failed_i))
    else $error("device fault lamp wrong");
  a_unconf_blink: assert property (powerup_done_o && $past(powerup_done_o) && !$past(configured_i)
    |-> chan_amber_led_o == 8'h00 || chan_amber_led_o == 8'hFF)
    else $error("unconfigured blink split");
endmodule
bind ledseq_top ledseq_top_monitor mon (.*);
`default_nettype wire

// ---- tb/ledseq_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ledseq_top_tb;
  import ledseq_pkg::*;
  // ----
  // signals
  // ----
  logic clock_i, arst_n_i, analog_variant_i, device_failed_i, configured_i, low_power_i;
  logic [7:0] dial, field_network_node_i, chan_active_i, chan_cfg_ok_i, chan_low_alarm_i;
  logic [7:0] chan_high_alarm_i, chan_out_of_range_i, chan_red_led_o, chan_amber_led_o;
  logic [7:0] er, mr, ea, ma, bl;
  logic dev_power_led_o, dev_fault_led_o, powerup_done_o, ef, v;
  integer errors = 0, check_count = 0, cyc = 0, seed = 32'hE0C0, i, lit;
  logic [15:0] seen[$];
  logic [15:0] w;
  ledseq_panel panel (.dial_i(dial), .sw_o(field_network_node_i));
  // short counts keep the run brief
  ledseq_top #(.STEP_CYC(4), .BLINK_CYC(6), .ADDR_CYC(20)) dut (.*);
  always #12.5 clock_i = ~clock_i;
  // hang guard
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      errors = errors + 1;
      wrap_up;
    end
  end
  // ----
  // tasks
  // ----
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
    check_count = check_count + 1;
    if (((g ^ e) & m) !== 8'h00)
    begin
      errors = errors + 1;
      $display("mismatch %s exp %h got %h", n, e & m, g & m);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [7:0] wf(input integer s);
    return s <= 8 ? 8'hFF >> (8 - s) : 8'hFF << (s - 8);
  endfunction
  // lamp states are logged on change, so step timing cannot hide order faults
  task automatic powerup;
    logic [7:0] d;
    d = 8'($random(seed));
    d = d == 8'h00 ? 8'h5A : d;
    @(posedge clock_i);
    arst_n_i <= 1'b0;
    dial <= d;
    repeat (8) @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
    seen.delete();
    w = 16'h0000;
    repeat (300)
    begin
      @(negedge clock_i);
      if (powerup_done_o === 1'b1)
        break;
      chk("power", 8'h01, {7'h0, dev_power_led_o}, 8'h01);
      chk("fault", 8'h01, {7'h0, dev_fault_led_o}, 8'h01);
      if ({chan_red_led_o, chan_amber_led_o} !== w)
      begin
        w = {chan_red_led_o, chan_amber_led_o};
        seen.push_back(w);
      end
    end
    chk("done", 8'h01, {7'h0, powerup_done_o}, 8'h01);
    // last amber step and the address land on one edge: 32 patterns in all
    chk("steps", 8'd32, 8'(seen.size()), 8'hFF);
    for (i = 1; i <= 32 && i <= seen.size(); i++)
    begin
      w = i > 16 ? {8'h00, wf(i - 16)} : {wf(i), 8'h00};
      w = i == 32 ? {d, 8'h00} : w;
      chk("red", w[15:8], seen[i - 1][15:8], 8'hFF);
      chk("amber", w[7:0], seen[i - 1][7:0], 8'hFF);
    end
    $display("power-up test over");
  endtask
  // blinking bits are masked: their phase is free running
  task automatic run(input integer p);
    v = 1'b0;
    lit = 0;
    repeat (150)
    begin
      @(posedge clock_i);
      {device_failed_i, low_power_i, chan_active_i, chan_cfg_ok_i, chan_low_alarm_i, chan_high_alarm_i,
        chan_out_of_range_i} <= 42'({$random(seed), $random(seed)});
      configured_i <= ($random(seed) & 7) != 0;
      analog_variant_i <= p[0];
      @(negedge clock_i);
      if (v)
      begin
        chk("red", er, chan_red_led_o, mr);
        chk("amber", ea, chan_amber_led_o, ma);
        chk("fault", {7'h0, ef}, {7'h0, dev_fault_led_o}, 8'h01);
        // all-blinking cycles must sometimes show every amber lamp lit together
        lit = lit + ((ma == 8'h00 && chan_amber_led_o === 8'hFF) ? 1 : 0);
      end
      v = 1'b1;
      bl = low_power_i ? 8'hFF : ~chan_cfg_ok_i;
      ef = device_failed_i;
      ea = configured_i && analog_variant_i ? chan_out_of_range_i : 8'h00;
      ma = configured_i ? ~(bl & ~ea) : 8'h00;
      er = !configured_i ? 8'h00 : analog_variant_i ? chan_high_alarm_i : chan_active_i;
      mr = configured_i && analog_variant_i ? ~(chan_low_alarm_i & ~chan_high_alarm_i) : 8'hFF;
    end
    chk("blink", 8'h01, {7'h0, lit > 0}, 8'h01);
    $display("run test %0d over", p);
  endtask
  // main sequence: second pass resets in mid-run
  initial
  begin
    {clock_i, arst_n_i, analog_variant_i, device_failed_i, configured_i, low_power_i, dial} = 14'h0;
    {chan_active_i, chan_cfg_ok_i, chan_low_alarm_i, chan_high_alarm_i, chan_out_of_range_i} = 40'h0;
    for (int p = 0; p < 2; p++)
    begin
      powerup;
      run(p);
    end
    wrap_up;
  end
endmodule
`default_nettype wire

// ---- verilog/ledseq_consts.svh ----
`ifndef LEDSEQ_CONSTS_SVH
`define LEDSEQ_CONSTS_SVH
// clock rate in Hz
`define LEDSEQ_CLK_HZ 40000000
// address display time in ms, and its cycle count
`define LEDSEQ_ADDR_MS 2000
`define LEDSEQ_ADDR_CYC ((`LEDSEQ_CLK_HZ / 1000) * `LEDSEQ_ADDR_MS)
// lamp-test step time and blink half period in ms
`define LEDSEQ_STEP_MS 100
`define LEDSEQ_STEP_CYC ((`LEDSEQ_CLK_HZ / 1000) * `LEDSEQ_STEP_MS)
`define LEDSEQ_BLINK_MS 250
`define LEDSEQ_BLINK_CYC ((`LEDSEQ_CLK_HZ / 1000) * `LEDSEQ_BLINK_MS)
// number of channels
`define LEDSEQ_NCH 8
`endif

// ---- verilog/ledseq_pkg.sv ----
`default_nettype none
package ledseq_pkg;
  // power-up phases and the run phase
  typedef enum logic [2:0] {
    LEDSEQ_ST_START,
    LEDSEQ_ST_RED_ON,
    LEDSEQ_ST_RED_OFF,
    LEDSEQ_ST_AMB_ON,
    LEDSEQ_ST_AMB_OFF,
    LEDSEQ_ST_ADDR,
    LEDSEQ_ST_RUN
  } ledseq_state_t;
endpackage
`default_nettype wire

// ---- verilog/ledseq_tick.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ledseq_consts.svh"
// one-cycle enable pulse every period_i cycles
module ledseq_tick
  import ledseq_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // control
  input wire logic [31:0] period_i,
  input wire logic clear_i,
  output logic tick_o
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } ledseq_tick_s_t;
  ledseq_tick_s_t s_r;
  ledseq_tick_s_t s_nxt;
  // count up and pulse at the end of each period
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (clear_i)
    begin
      s_nxt.cnt = 32'h0;
    end
    else if (s_r.cnt + 32'h1 >= period_i)
    begin
      s_nxt.cnt = 32'h0;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  assign tick_o = s_r.tick;
endmodule
`default_nettype wire

// ---- verilog/ledseq_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ledseq_consts.svh"
// Function
// - power and fault lit before channel test
// - red lamps on in turn 1 to 8
// - then red lamps off in turn 1 to 8
// - same walk on amber channel lamps
// - red lamp n shows address switch n
// - address shown for two seconds
// - device fault lamp off after address
// - unconfigured blinks all amber lamps together
// - green lamp on from the first clock after reset, dark while reset is held
// - device amber steady when failed
// - device amber lit steady through power-up
// - relay variant: red steady while channel active
// - amber blinks on low power or unconfigured
// - analog variant: red blink low, steady high
module ledseq_top
  import ledseq_pkg::*;
#(
  parameter int unsigned STEP_CYC = `LEDSEQ_STEP_CYC,
  parameter int unsigned BLINK_CYC = `LEDSEQ_BLINK_CYC,
  parameter int unsigned ADDR_CYC = `LEDSEQ_ADDR_CYC
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // configuration
  input wire logic analog_variant_i,
  input wire logic [7:0] field_network_node_i,
  // device status
  input wire logic device_failed_i,
  input wire logic configured_i,
  input wire logic low_power_i,
  // channel status
  input wire logic [7:0] chan_active_i,
  input wire logic [7:0] chan_cfg_ok_i,
  input wire logic [7:0] chan_low_alarm_i,
  input wire logic [7:0] chan_high_alarm_i,
  input wire logic [7:0] chan_out_of_range_i,
  // indicators
  output logic dev_power_led_o,
  output logic dev_fault_led_o,
  output logic [7:0] chan_red_led_o,
  output logic [7:0] chan_amber_led_o,
  output logic powerup_done_o
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    ledseq_state_t st;
    logic [2:0] idx;
    logic [31:0] addr_cnt;
    logic [7:0] addr;
    logic blink;
    logic green;
    logic fault;
    logic [7:0] red;
    logic [7:0] amber;
    logic done;
  } ledseq_s_t;
  ledseq_s_t s_r;
  ledseq_s_t s_nxt;
  logic step_tick;
  logic blink_tick;
  // blink phase after this edge, and the per-channel run-time lamp levels
  logic blink_now;
  logic [7:0] run_red;
  logic [7:0] run_amber;

  // -----------------------------------------------------------------
  // timebases
  // -----------------------------------------------------------------
  // the step timer runs free from reset; its first tick only leaves the start phase,
  // so the power and fault lamps stand alone for two full steps before the walk
  ledseq_tick u_step
  (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .period_i(STEP_CYC),
    .clear_i(1'b0),
    .tick_o(step_tick)
  );
  // blink runs free so all channels share one phase
  ledseq_tick u_blink
  (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .period_i(BLINK_CYC),
    .clear_i(1'b0),
    .tick_o(blink_tick)
  );

  // one-hot mask of a channel index
  function automatic logic [7:0] ledseq_bit(input logic [2:0] i);
    ledseq_bit = 8'h01 << i;
  endfunction

  // -----------------------------------------------------------------
  // run-time channel decode
  // -----------------------------------------------------------------
  // red lamp of one channel once running; a high alarm outranks a low alarm,
  // since a steady lamp cannot show a blink at the same time
  function automatic logic ledseq_red_run
  (
    input logic cfg,
    input logic analog,
    input logic active,
    input logic low,
    input logic high,
    input logic blk
  );
    if (!cfg)
    begin
      ledseq_red_run = 1'b0;
    end
    else if (analog)
    begin
      ledseq_red_run = high | (low & blk);
    end
    else
    begin
      ledseq_red_run = active;
    end
  endfunction

  // amber lamp of one channel once running; in the analog variant out of range is steady and beats the
  // low-power or bad-configuration blink, and an unconfigured module blinks them all
  function automatic logic ledseq_amber_run
  (
    input logic cfg,
    input logic analog,
    input logic low_pwr,
    input logic cfg_ok,
    input logic oor,
    input logic blk
  );
    if (!cfg)
    begin
      ledseq_amber_run = blk;
    end
    else if (analog && oor)
    begin
      ledseq_amber_run = 1'b1;
    end
    else
    begin
      ledseq_amber_run = (low_pwr | ~cfg_ok) & blk;
    end
  endfunction

  // every channel reads the same blink phase, so unconfigured lamps stay in step
  assign blink_now = blink_tick ? ~s_r.blink : s_r.blink;
  for (genvar ch = 0; ch < `LEDSEQ_NCH; ch++)
  begin : g_chan
    assign run_red[ch] = ledseq_red_run(configured_i, analog_variant_i, chan_active_i[ch],
      chan_low_alarm_i[ch], chan_high_alarm_i[ch], blink_now);
    assign run_amber[ch] = ledseq_amber_run(configured_i, analog_variant_i, low_power_i,
      chan_cfg_ok_i[ch], chan_out_of_range_i[ch], blink_now);
  end

  // -----------------------------------------------------------------
  // sequencer and indicator logic
  // -----------------------------------------------------------------
  // next state and lamps; the walk states never look at the status inputs
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.green = 1'b1;
    if (blink_tick)
    begin
      s_nxt.blink = ~s_r.blink;
    end
    case (s_r.st)
      // power and fault lamps alone, channel lamps dark
      LEDSEQ_ST_START:
      begin
        s_nxt.fault = 1'b1;
        s_nxt.red = 8'h00;
        s_nxt.amber = 8'h00;
        s_nxt.idx = 3'h0;
        if (step_tick)
        begin
          s_nxt.st = LEDSEQ_ST_RED_ON;
        end
      end
      // one more red lamp per step, channel 1 first; idx wraps to 0 for the next walk
      LEDSEQ_ST_RED_ON:
      begin
        if (step_tick)
        begin
          s_nxt.red = s_r.red | ledseq_bit(s_r.idx);
          s_nxt.idx = s_r.idx + 3'h1;
          if (s_r.idx == 3'h7)
          begin
            s_nxt.st = LEDSEQ_ST_RED_OFF;
          end
        end
      end
      // red lamps go dark in the same order
      LEDSEQ_ST_RED_OFF:
      begin
        if (step_tick)
        begin
          s_nxt.red = s_r.red & ~ledseq_bit(s_r.idx);
          s_nxt.idx = s_r.idx + 3'h1;
          if (s_r.idx == 3'h7)
          begin
            s_nxt.st = LEDSEQ_ST_AMB_ON;
          end
        end
      end
      // the same walk on the amber channel lamps
      LEDSEQ_ST_AMB_ON:
      begin
        if (step_tick)
        begin
          s_nxt.amber = s_r.amber | ledseq_bit(s_r.idx);
          s_nxt.idx = s_r.idx + 3'h1;
          if (s_r.idx == 3'h7)
          begin
            s_nxt.st = LEDSEQ_ST_AMB_OFF;
          end
        end
      end
      // the last amber step also latches the switches and shows them on red
      LEDSEQ_ST_AMB_OFF:
      begin
        if (step_tick)
        begin
          s_nxt.amber = s_r.amber & ~ledseq_bit(s_r.idx);
          s_nxt.idx = s_r.idx + 3'h1;
          if (s_r.idx == 3'h7)
          begin
            // switches sampled once here; they are assumed stable
            s_nxt.addr = field_network_node_i;
            s_nxt.red = field_network_node_i;
            s_nxt.addr_cnt = 32'h0;
            s_nxt.st = LEDSEQ_ST_ADDR;
          end
        end
      end
      // switches are not read again; a switch moved now shows at the next reset only
      LEDSEQ_ST_ADDR:
      begin
        s_nxt.red = s_r.addr;
        s_nxt.addr_cnt = s_r.addr_cnt + 32'h1;
        if (s_r.addr_cnt + 32'h1 >= ADDR_CYC)
        begin
          s_nxt.fault = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.st = LEDSEQ_ST_RUN;
        end
      end
      LEDSEQ_ST_RUN:
      begin
        // status inputs count only from here on
        s_nxt.fault = device_failed_i;
        s_nxt.red = run_red;
        s_nxt.amber = run_amber;
      end
      // unused state codes fall back to the start phase; done and the latched address keep their values
      default:
      begin
        s_nxt.st = LEDSEQ_ST_START;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  // async reset puts every lamp dark and the sequencer back at the start
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  // outputs straight from the state register
  assign dev_power_led_o = s_r.green;
  assign dev_fault_led_o = s_r.fault;
  assign chan_red_led_o = s_r.red;
  assign chan_amber_led_o = s_r.amber;
  assign powerup_done_o = s_r.done;
endmodule
`default_nettype wire
